// ### core/tes_pkg.sv
package tes_pkg;

    // timing
    localparam int CLK_FREQ_MHZ = 50;
    localparam int WR_TIME_US = 5000;
    // longest time: an exact whole number of cycles
    localparam int WR_CYCLES = WR_TIME_US * CLK_FREQ_MHZ;
    localparam int WCNT_W = 24;

    // array and page geometry
    localparam int ADDR_MAX_W = 11;
    localparam int PAGE_MAX = 16;
    localparam int PAGE_IDX_W = 4;
    localparam int PAGE_BYTES_2K = 8;
    localparam int PAGE_BYTES_BIG = 16;
    localparam int SEL_PINS = 3;

    // device address word layout
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam int DEV_TYPE_POS = 4;
    localparam int DEV_SEL_POS = 1;
    localparam int DEV_RW_POS = 0;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    typedef enum logic [3:0] {
        TES_IDLE,
        TES_DEV,
        TES_WADDR,
        TES_WDATA,
        TES_ACK,
        TES_RDATA,
        TES_RACK,
        TES_WRITE
    } tes_state_t;

    typedef struct packed {
        tes_state_t st;
        tes_state_t nxt;
        logic [7:0] sr;
        logic [3:0] cnt;
        logic [2:0] pg;
        logic [ADDR_MAX_W-1:0] addr;
        logic [7:0] tx;
        logic oe;
        logic acked;
        logic [PAGE_MAX*8-1:0] pbuf;
        logic [PAGE_MAX-1:0] pmask;
        logic [WCNT_W-1:0] wcnt;
        logic [PAGE_IDX_W:0] widx;
        logic stby;
        logic busy;
    } tes_core_t;

    localparam tes_core_t CORE_RST = '{st: TES_IDLE, nxt: TES_IDLE, stby: 1'b1, default: '0};

    // sampled pins: {sel[2:0], wp, sda, scl}
    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic scl_p;
        logic sda_p;
    } tes_sync_t;

    localparam tes_sync_t SYNC_RST = '{s1: 6'h03, s2: 6'h03, scl_p: 1'b1, sda_p: 1'b1};

endpackage

// ### core/tes_line_if.sv
`timescale 1ns/100ps
interface tes_line_if;
    logic scl;
    logic sda;
    logic wp;
    logic [2:0] sel;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;

    modport src (
        output scl, sda, wp, sel, scl_rise, scl_fall, start, stop
    );
    modport dst (
        input scl, sda, wp, sel, scl_rise, scl_fall, start, stop
    );
endinterface

// ### core/tes_line_sync.sv
`timescale 1ns/100ps
module tes_line_sync (
    // system
    input wire logic clk_sys,
    input wire logic srst,
    // raw pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic wp_i,
    input wire logic [2:0] sel_i,
    // conditioned bus events
    tes_line_if.src line
);
    import tes_pkg::*;

    tes_sync_t s_q;
    tes_sync_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.s1 = {sel_i, wp_i, sda_i, scl_i};
        s_d.s2 = s_q.s1;
        s_d.scl_p = s_q.s2[0];
        s_d.sda_p = s_q.s2[1];
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= SYNC_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign line.scl = s_q.s2[0];
    assign line.sda = s_q.s2[1];
    assign line.wp = s_q.s2[2];
    assign line.sel = s_q.s2[5:3];
    // data is taken on the rising edge, launched after the falling one
    assign line.scl_rise = s_q.s2[0] & ~s_q.scl_p;
    assign line.scl_fall = ~s_q.s2[0] & s_q.scl_p;
    // a data edge while the clock stays high frames a command
    assign line.start = s_q.s2[0] & s_q.scl_p & s_q.sda_p & ~s_q.s2[1];
    assign line.stop = s_q.s2[0] & s_q.scl_p & ~s_q.sda_p & s_q.s2[1];
endmodule

// ### core/tes_slave.sv
`timescale 1ns/100ps
// Operation
// - 2K: all three select pins matched
// - 4K: upper two select pins matched
// - 8K: only highest select pin matched
// - 16K: select pins ignored entirely
// - data line only pulled low or released
// - sample on rising, launch after falling
// - write protect high blocks all writes
// - write protect low allows normal access
// - 2K: 32 pages of 8, 8-bit address
// - 4K: 32 pages of 16, 9-bit address
// - 8K: 64 pages of 16, 10-bit address
// - 16K: 128 pages of 16, 11-bit address
// - data changes only while clock low
// - falling data, clock high: start
// - rising data, clock high: stop, standby
// - acknowledge each word in ninth clock
// - standby at power-up and after stop
// - page write of 8 or 16 bytes
// - partial pages commit only received bytes
// - self-timed write cycle, at most 5 ms
// - eighth address bit selects read/write
// - acknowledge on match, else standby silently
// - unused select bits are upper address
// - ignore bus during internal write
module tes_slave #(
    parameter int CAP_KBIT = 2,
    parameter int WR_CYCLES = tes_pkg::WR_CYCLES
) (
    // system
    input wire logic clk_sys,
    input wire logic srst,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // straps
    input wire logic device_select_pin_0,
    input wire logic device_select_pin_1,
    input wire logic device_select_pin_2,
    input wire logic write_protect,
    // status
    output logic standby,
    output logic write_busy
);
    import tes_pkg::*;

    // capacity in kbit sets address width: 2K->8 ... 16K->11
    localparam int AW = $clog2(CAP_KBIT) + 7;
    localparam int MEM_BYTES = 1 << AW;
    localparam int PAGE_BYTES = (CAP_KBIT == 2) ? PAGE_BYTES_2K : PAGE_BYTES_BIG;
    // number of select pins that take part in matching
    localparam int NSEL = (CAP_KBIT == 2) ? 3 : (CAP_KBIT == 4) ? 2 : (CAP_KBIT == 8) ? 1 : 0;
    localparam logic [ADDR_MAX_W-1:0] ADDR_MASK = ADDR_MAX_W'((1 << AW) - 1);
    localparam logic [ADDR_MAX_W-1:0] PAGE_MASK = ADDR_MAX_W'(PAGE_BYTES - 1);
    localparam logic [PAGE_IDX_W:0] PAGE_CNT = (PAGE_IDX_W + 1)'(PAGE_BYTES);
    localparam logic [2:0] SEL_MASK = 3'((7 << (SEL_PINS - NSEL)) & 7);
    localparam logic [WCNT_W-1:0] WR_LAST = WCNT_W'(WR_CYCLES - 1);

    if (!(CAP_KBIT == 2 || CAP_KBIT == 4 || CAP_KBIT == 8 || CAP_KBIT == 16)) begin : g_bad_cap
        $error("CAP_KBIT must be 2, 4, 8 or 16");
    end
    if (WR_CYCLES < 1 || WR_CYCLES >= (1 << WCNT_W)) begin : g_bad_wr
        $error("WR_CYCLES out of range");
    end

    // wraps within the current page during writes
    function automatic logic [ADDR_MAX_W-1:0] page_inc(input logic [ADDR_MAX_W-1:0] a);
        return (a & ~PAGE_MASK) | ((a + 1'b1) & PAGE_MASK);
    endfunction

    // wraps from the last byte of the array to the first during reads
    function automatic logic [ADDR_MAX_W-1:0] lin_inc(input logic [ADDR_MAX_W-1:0] a);
        return (a + 1'b1) & ADDR_MASK;
    endfunction

    tes_line_if line ();

    tes_line_sync u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .wp_i(write_protect),
        .sel_i({device_select_pin_2, device_select_pin_1, device_select_pin_0}),
        .line(line)
    );

    logic [7:0] mem [0:MEM_BYTES-1];
    tes_core_t s_q;
    tes_core_t s_d;
    logic mem_we;
    logic [ADDR_MAX_W-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic load_rd;
    logic dev_match;
    logic [7:0] rd_byte;
    logic [PAGE_IDX_W-1:0] pidx;

    // no reset for the array: its contents outlive any reset, like the cells
    initial begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] = ERASED_BYTE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_wa[AW-1:0]] <= mem_wd;
        end
    end

    assign rd_byte = mem[s_q.addr[AW-1:0]];
    assign pidx = PAGE_IDX_W'(s_q.addr & PAGE_MASK);
    assign dev_match = (s_q.sr[7:DEV_TYPE_POS] == DEV_TYPE_CODE)
        && (((s_q.sr[DEV_SEL_POS +: 3] ^ line.sel) & SEL_MASK) == 3'h0);

    always_comb begin
        s_d = s_q;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = '0;
        load_rd = 1'b0;
        if (s_q.st == TES_WRITE) begin
            // bus is not looked at until the cycle ends; polling goes unanswered
            s_d.wcnt = s_q.wcnt + 1'b1;
            if (s_q.widx != PAGE_CNT) begin
                // only bytes actually received are committed
                mem_we = s_q.pmask[s_q.widx[PAGE_IDX_W-1:0]];
                mem_wa = (s_q.addr & ~PAGE_MASK) | ADDR_MAX_W'(s_q.widx);
                mem_wd = s_q.pbuf[s_q.widx[PAGE_IDX_W-1:0] * 8 +: 8];
                s_d.widx = s_q.widx + 1'b1;
            end
            if (s_q.wcnt == WR_LAST) begin
                s_d.st = TES_IDLE;
                s_d.pmask = '0;
            end
        end else if (line.stop) begin
            s_d.oe = 1'b0;
            s_d.cnt = '0;
            if (s_q.pmask != '0 && !line.wp) begin
                s_d.st = TES_WRITE;
                s_d.wcnt = '0;
                s_d.widx = '0;
            end else begin
                // protected or read-only sequence: straight to standby
                s_d.st = TES_IDLE;
                s_d.pmask = '0;
            end
        end else if (line.start) begin
            // a start aborts any unfinished sequence and its buffered bytes
            s_d.st = TES_DEV;
            s_d.cnt = '0;
            s_d.oe = 1'b0;
            s_d.pmask = '0;
        end else begin
            unique case (s_q.st)
                TES_IDLE: begin
                end
                TES_DEV, TES_WADDR, TES_WDATA: begin
                    if (line.scl_rise) begin
                        s_d.sr = {s_q.sr[6:0], line.sda};
                        s_d.cnt = s_q.cnt + 1'b1;
                    end else if (line.scl_fall && s_q.cnt == BITS_PER_WORD) begin
                        s_d.cnt = '0;
                        s_d.st = TES_ACK;
                        s_d.oe = 1'b1;
                        if (s_q.st == TES_DEV) begin
                            s_d.pg = s_q.sr[DEV_SEL_POS +: 3];
                            s_d.nxt = s_q.sr[DEV_RW_POS] ? TES_RDATA : TES_WADDR;
                            if (!dev_match) begin
                                s_d.st = TES_IDLE;
                                s_d.oe = 1'b0;
                            end
                        end else if (s_q.st == TES_WADDR) begin
                            // select bits not used for matching sit above the byte
                            s_d.addr = {s_q.pg, s_q.sr} & ADDR_MASK;
                            s_d.nxt = TES_WDATA;
                        end else begin
                            // acked even under protection; dropped at stop
                            s_d.pbuf[pidx * 8 +: 8] = s_q.sr;
                            s_d.pmask[pidx] = 1'b1;
                            s_d.addr = page_inc(s_q.addr);
                            s_d.nxt = TES_WDATA;
                        end
                    end
                end
                TES_ACK: begin
                    if (line.scl_fall) begin
                        s_d.oe = 1'b0;
                        s_d.st = s_q.nxt;
                        load_rd = (s_q.nxt == TES_RDATA);
                    end
                end
                TES_RDATA: begin
                    if (line.scl_rise) begin
                        s_d.cnt = s_q.cnt + 1'b1;
                    end else if (line.scl_fall) begin
                        if (s_q.cnt == BITS_PER_WORD) begin
                            s_d.oe = 1'b0;
                            s_d.cnt = '0;
                            s_d.st = TES_RACK;
                        end else begin
                            s_d.tx = {s_q.tx[6:0], 1'b0};
                            s_d.oe = ~s_q.tx[6];
                        end
                    end
                end
                TES_RACK: begin
                    if (line.scl_rise) begin
                        s_d.acked = ~line.sda;
                    end else if (line.scl_fall) begin
                        if (s_q.acked) begin
                            s_d.st = TES_RDATA;
                            load_rd = 1'b1;
                        end else begin
                            // no ack: release and wait for the stop
                            s_d.st = TES_IDLE;
                        end
                    end
                end
                default: begin
                    s_d.st = TES_IDLE;
                    s_d.oe = 1'b0;
                end
            endcase
        end
        if (load_rd) begin
            // first bit goes out right after the falling edge
            s_d.tx = rd_byte;
            s_d.addr = lin_inc(s_q.addr);
            s_d.oe = ~rd_byte[7];
        end
        s_d.stby = (s_d.st == TES_IDLE);
        s_d.busy = (s_d.st == TES_WRITE);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= CORE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: the driven level is always low
    assign sda_o = 1'b0;
    assign sda_oe = s_q.oe;
    assign standby = s_q.stby;
    assign write_busy = s_q.busy;
endmodule

// ### verif/tes_slave_props.sv
`timescale 1ns/100ps
module tes_slave_props #(
    parameter int CAP_KBIT = 2,
    parameter int WR_CYCLES = 250000
) (
    // system
    input wire logic clk_sys,
    input wire logic srst,
    // bus and strap
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic write_protect,
    // status
    input wire logic standby,
    input wire logic write_busy
);
    // length of the current write cycle, read on the cycle it ends
    logic [23:0] bcnt_q;
    always_ff @(posedge clk_sys) begin
        bcnt_q <= (srst || !write_busy) ? 24'h0 : bcnt_q + 24'h1;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    sda_low_a: assert property (sda_o == 1'b0) else $error("sda_o high");
    busy_no_stby_a: assert property (write_busy |-> !standby) else $error("busy in standby");
    busy_silent_a: assert property (write_busy |-> !sda_oe) else $error("drive while busy");
    stby_quiet_a: assert property (standby |-> !sda_oe) else $error("drive in standby");
    oe_clk_low_a: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("sda_oe moved with clock high");
    oe_holds_a: assert property ($rose(scl_i) |-> $stable(sda_oe) [*3])
        else $error("sda_oe moved after clock rise");
    wr_time_a: assert property ($fell(write_busy) |-> bcnt_q <= WR_CYCLES && bcnt_q + 2 >= WR_CYCLES)
        else $error("write cycle length");
    stop_idle_a: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] (standby || write_busy))
        else $error("no standby after stop");
    busy_idle_a: assert property ($rose(write_busy) |-> scl_i && sda_i)
        else $error("write began on busy bus");
    wp_blocks_a: assert property ($rose(write_busy) |-> !$past(write_protect, 8))
        else $error("protected write started");
    cover property ($rose(write_busy));
    cover property ($rose(sda_oe) && !standby);
    cover property ($fell(standby));
endmodule
bind tes_slave tes_slave_props #(.CAP_KBIT(CAP_KBIT), .WR_CYCLES(WR_CYCLES)) u_props (
    .clk_sys(clk_sys), .srst(srst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .write_protect(write_protect), .standby(standby), .write_busy(write_busy));

// ### verif/tes_ctl_model.sv
`timescale 1ns/100ps
module tes_ctl_model (
    // system
    input wire logic clk_sys,
    // bus
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    // clock parked high between frames; low phase 5 clk, high 3 clk
    initial begin
        scl = 1'b1;
        sda_drv = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // pull low or release only, data moved with clock low
    task automatic bit_io(input logic b, output logic s);
        hold(2);
        sda_drv = ~b;
        hold(3);
        scl = 1'b1;
        hold(3);
        s = sda;
        scl = 1'b0;
    endtask
    // also a repeated start
    task automatic ctl_start();
        hold(2);
        sda_drv = 1'b0;
        hold(3);
        scl = 1'b1;
        hold(3);
        sda_drv = 1'b1;
        hold(3);
        scl = 1'b0;
    endtask
    task automatic ctl_stop();
        hold(2);
        sda_drv = 1'b1;
        hold(3);
        scl = 1'b1;
        hold(3);
        sda_drv = 1'b0;
        hold(4);
    endtask
    // msb first, ninth bit released for the answer
    task automatic ctl_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic ctl_read(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask
    // nine released clocks, then a start
    task automatic ctl_recover();
        logic s;
        for (int i = 0; i < 9; i++) bit_io(1'b1, s);
        ctl_start();
    endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import tes_pkg::*;
    localparam int WRC = 200;
    localparam logic [2:0] SEL = 3'h5;
    logic clk_sys = 1'b0;
    logic srst;
    logic wp;
    logic [2:0] sel;
    logic sda_oe, sda_o, standby, write_busy, scl, m_oe;
    wire logic sda;
    int errors = 0;
    int comparisons = 0;
    // pull-up wire
    assign sda = ~(sda_oe | m_oe);
    always #10 clk_sys = ~clk_sys;
    tes_slave #(.CAP_KBIT(2), .WR_CYCLES(WRC)) dut (.clk_sys(clk_sys), .srst(srst),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .device_select_pin_0(sel[0]), .device_select_pin_1(sel[1]),
        .device_select_pin_2(sel[2]), .write_protect(wp), .standby(standby),
        .write_busy(write_busy));
    tes_ctl_model m (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_drv(m_oe));
    task automatic end_sim();
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic sendb(input logic [7:0] d, input logic e);
        logic a;
        m.ctl_byte(d, a);
        chk("ack", e, a);
    endtask
    function automatic logic [7:0] dw(input logic rd);
        return {DEV_TYPE_CODE, SEL, rd};
    endfunction
    task automatic wr_hdr(input logic [7:0] a);
        m.ctl_start();
        sendb(dw(1'b0), 1'b1);
        sendb(a, 1'b1);
    endtask
    task automatic rd_hdr(input logic [7:0] a);
        wr_hdr(a);
        m.ctl_start();
        sendb(dw(1'b1), 1'b1);
    endtask
    task automatic rd_byte(input logic last, input logic [7:0] e);
        logic [7:0] d;
        m.ctl_read(last, d);
        chk("rdata", e, d);
    endtask
    task automatic wait_idle();
        int i;
        m.hold(4);
        for (i = 0; i < WRC + 50 && write_busy !== 1'b0; i++) @(negedge clk_sys);
        if (i >= WRC + 50) begin
            errors++;
            end_sim();
        end
        m.hold(2);
    endtask
    task automatic t_reset();
        chk("standby", 8'h01, standby);
        chk("write_busy", 8'h00, write_busy);
        chk("sda_oe", 8'h00, sda_oe);
        chk("sda_o", 8'h00, sda_o);
    endtask
    task automatic t_byte_rw();
        wr_hdr(8'h12);
        sendb(8'h5A, 1'b1);
        m.ctl_stop();
        m.hold(3);
        chk("write_busy", 8'h01, write_busy);
        wait_idle();
        chk("standby", 8'h01, standby);
        rd_hdr(8'h12);
        rd_byte(1'b1, 8'h5A);
        m.ctl_stop();
    endtask
    // address word sent while the write cycle runs
    task automatic t_poll();
        wr_hdr(8'h13);
        sendb(8'hC3, 1'b1);
        m.ctl_stop();
        m.ctl_start();
        sendb(dw(1'b0), 1'b0);
        m.ctl_stop();
        wait_idle();
        rd_hdr(8'h13);
        rd_byte(1'b1, 8'hC3);
        m.ctl_stop();
    endtask
    // nine bytes into an 8-byte page wrap onto its first byte
    task automatic t_page();
        wr_hdr(8'h20);
        for (int i = 0; i < 9; i++) sendb(8'(8'h80 + i), 1'b1);
        m.ctl_stop();
        wait_idle();
        rd_hdr(8'h20);
        for (int i = 0; i < 8; i++) rd_byte(i == 7, i == 0 ? 8'h88 : 8'(8'h80 + i));
        m.ctl_stop();
        wr_hdr(8'h30);
        sendb(8'h11, 1'b1);
        sendb(8'h22, 1'b1);
        m.ctl_stop();
        wait_idle();
        rd_hdr(8'h30);
        rd_byte(1'b0, 8'h11);
        rd_byte(1'b0, 8'h22);
        rd_byte(1'b1, ERASED_BYTE);
        m.ctl_stop();
    endtask
    task automatic t_select();
        logic [7:0] d;
        for (int v = 0; v < 8; v++) begin
            sel = 3'(v);
            m.ctl_start();
            sendb(dw(1'b1), v == SEL);
            if (v == SEL)
                rd_byte(1'b1, ERASED_BYTE);
            m.ctl_stop();
        end
        // straps back to the value the address words below carry
        sel = SEL;
        m.ctl_start();
        sendb({4'hB, SEL, 1'b0}, 1'b0);
        m.ctl_stop();
        // abandon an address byte after its first bit, then recover
        m.ctl_start();
        sendb(dw(1'b0), 1'b1);
        m.bit_io(1'b0, d[0]);
        m.ctl_recover();
        sendb(dw(1'b1), 1'b1);
        rd_byte(1'b1, ERASED_BYTE);
        m.ctl_stop();
    endtask
    task automatic t_wp();
        wp = 1'b1;
        wr_hdr(8'h12);
        sendb(8'h00, 1'b1);
        m.ctl_stop();
        m.hold(8);
        chk("write_busy", 8'h00, write_busy);
        rd_hdr(8'h12);
        rd_byte(1'b1, 8'h5A);
        m.ctl_stop();
        wp = 1'b0;
    endtask
    initial begin
        srst = 1'b1;
        wp = 1'b0;
        sel = SEL;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        m.hold(3);
        t_reset();
        t_byte_rw();
        t_poll();
        t_page();
        t_select();
        t_wp();
        end_sim();
    end
endmodule
